// File: tcsio_consts.svh
// Constants of the cooler supervisory block
`ifndef TCSIO_CONSTS_SVH
`define TCSIO_CONSTS_SVH
`define TCSIO_ADDR_CTRL 8'h00
`define TCSIO_ADDR_CFG 8'h04
`define TCSIO_ADDR_TARGET 8'h08
`define TCSIO_ADDR_STATUS 8'h0c
`define TCSIO_ADDR_IRQ_STAT 8'h10
`define TCSIO_ADDR_IRQ_MASK 8'h14
`define TCSIO_ADDR_TEMP 8'h18
`define TCSIO_CFG_RST 32'h0000_0000
`define TCSIO_CFG_RUN_HI 0
`define TCSIO_CFG_CLR_HI 1
`define TCSIO_CFG_RDY_LO 2
`define TCSIO_CFG_RDY_OC 3
`define TCSIO_CFG_ATS_LO 4
`define TCSIO_CFG_ATS_OC 5
`define TCSIO_CFG_HOST_MODE 6
`define TCSIO_CTRL_HOST_RUN 0
`define TCSIO_CTRL_CLEAR 1
`define TCSIO_CTRL_BOOT_DONE 2
`define TCSIO_IRQ_SENSOR 0
`define TCSIO_IRQ_SHORT 1
`define TCSIO_IRQ_READY 2
`define TCSIO_IRQ_ATS 3
`define TCSIO_TOL 16'h0010
`define TCSIO_ADC_FULL 12'hfff
`define TCSIO_SPAN_50C 16'h0320
`endif

// File: tcsio_pkg.sv
// Types of the cooler supervisory block
package tcsio_pkg;
  typedef enum logic [1:0] {
    TCSIO_BOOT = 2'b00,
    TCSIO_IDLE = 2'b01,
    TCSIO_RUN = 2'b10,
    TCSIO_FAULT = 2'b11
  } tcsio_state_type;
  typedef struct packed {
    logic open;
    logic shorted;
    logic [15:0] temp;
  } tcsio_sensor_type;
endpackage : tcsio_pkg

// File: tcsio_top.sv
// Supervisory gating, fault latching and indicator outputs of the cooler controller
`timescale 1ns/1ps
`include "tcsio_consts.svh"
// What this block does
// - Run and clear inputs have separate polarity settings, both low-active by default.
// - Power stage and regulation run only while the run request is active.
// - Clear input clears latched errors without resetting the processor.
// - Ready and at-setpoint outputs have polarity and drive settings, default high push-pull.
// - Ready goes active once operational and drops on any internal error.
// - At-setpoint active only while enabled and temperature within one degree.
// - Open or shorted sensor enters the error state and disables output.
// - Hardware short-circuit detector cuts the power stage directly.
// - Analog target maps 0 to 5 V linearly onto 0 to 50 degrees.
// - A setting chooses analog or host target; host mode ignores the analog input.
// - Second analog input is reserved and unused; no analog outputs.
// - Host command protocol is the same on both physical link variants.
// - Host run request still needs the hardware run input active.
// - Host clear command clears errors exactly like the clear input.
module tcsio_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic run_request_input,
  input wire logic error_clear_input,
  input wire logic [11:0] analog_target_input,
  input wire logic [11:0] analog_spare_input,
  input wire tcsio_pkg::tcsio_sensor_type sensor,
  input wire logic short_detect,
  output logic stage_enable,
  output logic ready_out,
  output logic ready_oe,
  output logic at_target_out,
  output logic at_target_oe,
  output logic [15:0] target_temp,
  output logic irq
);
  tcsio_pkg::tcsio_state_type state_reg;
  tcsio_pkg::tcsio_state_type state_next;
  logic [31:0] cfg_reg;
  logic [15:0] host_target_reg;
  logic host_run_reg;
  logic boot_done_reg;
  logic clear_cmd_reg;
  logic [1:0] run_sync_reg;
  logic [1:0] clr_sync_reg;
  logic clr_prev_reg;
  logic [1:0] short_sync_reg;
  logic [1:0] sens_sync_reg;
  logic err_sensor_reg;
  logic err_short_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic [15:0] temp_reg;
  logic ready_prev_reg;
  logic ats_prev_reg;
  logic run_act;
  logic clear_pulse;
  logic enabled;
  logic near_target;
  logic ready_lvl;
  logic ats_lvl;
  logic [15:0] analog_target;
  logic [27:0] scaled;
  logic [3:0] events;

  // Polarity correction before synchronisation; config bit set means high-active
  always_ff @(posedge clk) begin
    if (rst) begin
      run_sync_reg <= 2'h0;
      clr_sync_reg <= 2'h0;
      short_sync_reg <= 2'h0;
      sens_sync_reg <= 2'h0;
    end else begin
      run_sync_reg <= {run_sync_reg[0], run_request_input ~^ cfg_reg[`TCSIO_CFG_RUN_HI]};
      clr_sync_reg <= {clr_sync_reg[0], error_clear_input ~^ cfg_reg[`TCSIO_CFG_CLR_HI]};
      short_sync_reg <= {short_sync_reg[0], short_detect};
      sens_sync_reg <= {sens_sync_reg[0], sensor.open | sensor.shorted};
    end
  end

  assign run_act = run_sync_reg[1];
  // Edge only, so a held clear switch does not mask a new fault
  always_ff @(posedge clk) begin
    if (rst) begin
      clr_prev_reg <= 1'b0;
    end else begin
      clr_prev_reg <= clr_sync_reg[1];
    end
  end
  assign clear_pulse = (clr_sync_reg[1] & ~clr_prev_reg) | clear_cmd_reg;

  // Fault latches; a still-present cause wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      err_sensor_reg <= 1'b0;
      err_short_reg <= 1'b0;
    end else begin
      if (sens_sync_reg[1]) begin
        err_sensor_reg <= 1'b1;
      end else if (clear_pulse) begin
        err_sensor_reg <= 1'b0;
      end
      if (short_sync_reg[1]) begin
        err_short_reg <= 1'b1;
      end else if (clear_pulse) begin
        err_short_reg <= 1'b0;
      end
    end
  end

  // Supervisory state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tcsio_pkg::TCSIO_BOOT: begin
        if (boot_done_reg) begin
          state_next = tcsio_pkg::TCSIO_IDLE;
        end
      end
      tcsio_pkg::TCSIO_IDLE: begin
        if (err_sensor_reg | err_short_reg) begin
          state_next = tcsio_pkg::TCSIO_FAULT;
        end else if (run_act & (host_run_reg | ~cfg_reg[`TCSIO_CFG_HOST_MODE])) begin
          state_next = tcsio_pkg::TCSIO_RUN;
        end
      end
      tcsio_pkg::TCSIO_RUN: begin
        if (err_sensor_reg | err_short_reg) begin
          state_next = tcsio_pkg::TCSIO_FAULT;
        end else if (~run_act | (cfg_reg[`TCSIO_CFG_HOST_MODE] & ~host_run_reg)) begin
          state_next = tcsio_pkg::TCSIO_IDLE;
        end
      end
      default: begin
        if (~err_sensor_reg & ~err_short_reg) begin
          state_next = tcsio_pkg::TCSIO_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= tcsio_pkg::TCSIO_BOOT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Stage cut directly by the synchronised short detector, no firmware path
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_enable <= 1'b0;
    end else begin
      stage_enable <= (state_next == tcsio_pkg::TCSIO_RUN) & ~short_sync_reg[1];
    end
  end

  // Analog target scaled linearly: full scale equals 50 degrees in 1/16 degree units
  assign scaled = 28'(analog_target_input) * 28'(`TCSIO_SPAN_50C);
  assign analog_target = 16'(scaled / 28'(`TCSIO_ADC_FULL));
  // Spare analog input deliberately unread
  always_ff @(posedge clk) begin
    if (rst) begin
      target_temp <= 16'h0000;
      temp_reg <= 16'h0000;
    end else begin
      target_temp <= cfg_reg[`TCSIO_CFG_HOST_MODE] ? host_target_reg : analog_target;
      temp_reg <= sensor.temp;
    end
  end

  assign enabled = (state_reg == tcsio_pkg::TCSIO_RUN);
  assign near_target = (temp_reg >= target_temp ? temp_reg - target_temp :
                        target_temp - temp_reg) <= `TCSIO_TOL;
  assign ready_lvl = (state_reg == tcsio_pkg::TCSIO_IDLE) | enabled;
  assign ats_lvl = enabled & near_target;

  // Open collector only sinks: enable when the pin level is low
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_out <= 1'b0;
      ready_oe <= 1'b1;
      at_target_out <= 1'b0;
      at_target_oe <= 1'b1;
      ready_prev_reg <= 1'b0;
      ats_prev_reg <= 1'b0;
    end else begin
      ready_out <= ready_lvl ^ cfg_reg[`TCSIO_CFG_RDY_LO];
      ready_oe <= ~cfg_reg[`TCSIO_CFG_RDY_OC] | ~(ready_lvl ^ cfg_reg[`TCSIO_CFG_RDY_LO]);
      at_target_out <= ats_lvl ^ cfg_reg[`TCSIO_CFG_ATS_LO];
      at_target_oe <= ~cfg_reg[`TCSIO_CFG_ATS_OC] | ~(ats_lvl ^ cfg_reg[`TCSIO_CFG_ATS_LO]);
      ready_prev_reg <= ready_lvl;
      ats_prev_reg <= ats_lvl;
    end
  end

  // Sticky events; set wins over write-one-to-clear
  assign events = {ats_lvl & ~ats_prev_reg, ready_prev_reg & ~ready_lvl,
                   short_sync_reg[1], sens_sync_reg[1]};
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_reg <= 4'h0;
      irq <= 1'b0;
    end else begin
      if (wr && addr == `TCSIO_ADDR_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~wdata[3:0]) | events;
      end else begin
        irq_stat_reg <= irq_stat_reg | events;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Register writes; the host link protocol layer sits outside and uses this port
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= `TCSIO_CFG_RST;
      host_target_reg <= 16'h0000;
      host_run_reg <= 1'b0;
      boot_done_reg <= 1'b0;
      clear_cmd_reg <= 1'b0;
      irq_mask_reg <= 4'h0;
    end else begin
      clear_cmd_reg <= 1'b0;
      if (wr) begin
        if (addr == `TCSIO_ADDR_CTRL) begin
          host_run_reg <= wdata[`TCSIO_CTRL_HOST_RUN];
          clear_cmd_reg <= wdata[`TCSIO_CTRL_CLEAR];
          boot_done_reg <= boot_done_reg | wdata[`TCSIO_CTRL_BOOT_DONE];
        end else if (addr == `TCSIO_ADDR_CFG) begin
          cfg_reg <= {25'h0000000, wdata[6:0]};
        end else if (addr == `TCSIO_ADDR_TARGET) begin
          host_target_reg <= wdata[15:0];
        end else if (addr == `TCSIO_ADDR_IRQ_MASK) begin
          irq_mask_reg <= wdata[3:0];
        end
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      if (addr == `TCSIO_ADDR_CTRL) begin
        rdata <= {29'h0000000, boot_done_reg, 1'b0, host_run_reg};
      end else if (addr == `TCSIO_ADDR_CFG) begin
        rdata <= cfg_reg;
      end else if (addr == `TCSIO_ADDR_TARGET) begin
        rdata <= {16'h0000, target_temp};
      end else if (addr == `TCSIO_ADDR_STATUS) begin
        rdata <= {24'h000000, ats_lvl, ready_lvl, err_short_reg, err_sensor_reg,
                  2'h0, state_reg};
      end else if (addr == `TCSIO_ADDR_IRQ_STAT) begin
        rdata <= {28'h0000000, irq_stat_reg};
      end else if (addr == `TCSIO_ADDR_IRQ_MASK) begin
        rdata <= {28'h0000000, irq_mask_reg};
      end else if (addr == `TCSIO_ADDR_TEMP) begin
        rdata <= {16'h0000, temp_reg};
      end else begin
        rdata <= 32'h0000_0000;
      end
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule : tcsio_top

// File: tcsio_checker_assertions.sv
// Port checker of the cooler supervisory block
`timescale 1ns/1ps
module tcsio_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [11:0] analog_spare_input,
  input wire tcsio_pkg::tcsio_sensor_type sensor,
  input wire logic short_detect,
  input wire logic stage_enable,
  input wire logic [15:0] target_temp,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Faults must cut the stage with no firmware in the path
  a_short_cuts_stage: assert property ($rose(short_detect) |-> ##[0:3] !stage_enable)
    else $error("stage on after short");
  // Two sync stages plus the output register before the cut shows
  a_short_holds_off: assert property (short_detect [*4] |-> !stage_enable)
    else $error("stage on during short");
  // Sensor path adds only the error latch; the stage register reads state_next
  a_open_stops: assert property (sensor.open [*5] |-> !stage_enable)
    else $error("stage on with open sensor");
  a_shorted_stops: assert property (sensor.shorted [*5] |-> !stage_enable)
    else $error("stage on with shorted sensor");
  a_stage_clean: assert property ($rose(stage_enable) |-> !short_detect && !sensor.open)
    else $error("stage rose during fault");
  a_reset_quiet: assert property ($fell(rst) |-> !stage_enable && !irq && rdata == 32'h0)
    else $error("outputs active after reset");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  a_spare_ignored: assert property ($changed(analog_spare_input) |=> ##1 $stable(target_temp))
    else $error("spare input moved target");
  // Main scenarios reached
  c_short: cover property ($rose(short_detect));
  c_stage: cover property ($rose(stage_enable));
  c_irq: cover property ($rose(irq));
endmodule : tcsio_checker
bind tcsio_top tcsio_checker chk_i (.clk(clk), .rst(rst), .rd(rd), .rdata(rdata),
  .analog_spare_input(analog_spare_input), .sensor(sensor), .short_detect(short_detect),
  .stage_enable(stage_enable), .target_temp(target_temp), .irq(irq));

// File: tcsio_host.sv
// Host controller model on the register port
`timescale 1ns/1ps
module tcsio_host (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd
);
  // Idle bus from time zero
  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Same word access whatever the physical link is
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr32
  // Data taken at the edge closing the answer slot
  task automatic rd32(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd32
endmodule : tcsio_host

// File: testbench.sv
// Self-checking bench of the cooler supervisory block
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  logic wr, rd, stage, rdy, rdy_oe, ats, ats_oe, irq;
  logic run_pin = 1'b1;
  logic clr_pin = 1'b1;
  logic short_det = 1'b0;
  logic [11:0] atgt = 12'h800;
  logic [11:0] spare = 12'h000;
  logic [15:0] tgt;
  tcsio_pkg::tcsio_sensor_type sensor = '{1'b0, 1'b0, 16'h0328};
  int err_total = 0;
  int n_tests = 0;
  tcsio_host host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  tcsio_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .run_request_input(run_pin), .error_clear_input(clr_pin),
    .analog_target_input(atgt), .analog_spare_input(spare), .sensor(sensor),
    .short_detect(short_det), .stage_enable(stage), .ready_out(rdy), .ready_oe(rdy_oe),
    .at_target_out(ats), .at_target_oe(ats_oe), .target_temp(tgt), .irq(irq));
  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // Watchdog, far beyond the expected run
  initial begin
    #20000;
    err_total++;
    wrap_up();
  end
  // Test sequence
  initial begin
    step(12);
    rst <= 1'b0;
    host.rd32(8'h04, v); `CHK(v, 32'h0);
    host.wr32(8'h40, 32'h1); host.rd32(8'h40, v); `CHK(v, 32'h0);
    `CHK(rdy, 1'b0);
    host.wr32(8'h00, 32'h4); step(4); `CHK({rdy, rdy_oe}, 2'b11);
    $display("test defaults done");
    run_pin <= 1'b0; step(5); `CHK(stage, 1'b1);
    `CHK(tgt, 16'h0190);
    atgt <= 12'hfff; step(4); `CHK(tgt, 16'h0320);
    `CHK(ats, 1'b1);
    sensor.temp <= 16'h0340; spare <= 12'h5a5; step(4); `CHK(ats, 1'b0);
    `CHK(tgt, 16'h0320);
    run_pin <= 1'b1; step(5); `CHK(stage, 1'b0);
    $display("test run done");
    host.wr32(8'h04, 32'h40); host.wr32(8'h08, 32'h123); atgt <= 12'h000; step(4);
    `CHK(tgt, 16'h0123);
    run_pin <= 1'b0; step(5); `CHK(stage, 1'b0);
    host.wr32(8'h00, 32'h1); step(4); `CHK(stage, 1'b1);
    // Host run alone must not hold the stage once the pin rises
    run_pin <= 1'b1; step(5); `CHK(stage, 1'b0);
    run_pin <= 1'b0; step(5);
    $display("test host done");
    // Fault path is sync, latch, state, output: five edges to settle
    host.wr32(8'h14, 32'h3); short_det <= 1'b1; step(6);
    `CHK({stage, rdy, irq}, 3'b001);
    host.rd32(8'h0c, v); `CHK(v[1:0], 2'h3);
    host.wr32(8'h00, 32'h3); step(4); `CHK(rdy, 1'b0);
    short_det <= 1'b0; host.wr32(8'h00, 32'h3); step(4);
    `CHK({rdy, stage}, 2'b11);
    host.wr32(8'h10, 32'h3); step(3); `CHK(irq, 1'b0);
    $display("test short done");
    sensor.open <= 1'b1; step(6); `CHK({stage, rdy, irq}, 3'b001);
    sensor.open <= 1'b0; clr_pin <= 1'b0; step(5); clr_pin <= 1'b1; step(4);
    `CHK(rdy, 1'b1);
    $display("test sensor done");
    host.wr32(8'h04, 32'h7d); step(5); `CHK({stage, rdy, rdy_oe}, 3'b001);
    `CHK(ats_oe, 1'b0);
    run_pin <= 1'b1; step(5); `CHK(stage, 1'b1);
    $display("test polarity done");
    wrap_up();
  end
endmodule : testbench
